// ==== logic/muxed_host_bus_port.sv ====
// Multiplexed address/data host port: latches an address, then moves one byte.
// Assumes storage (clock registers plus extended RAM) answers reads combinationally.
// Assumes each host phase lasts eight core clocks or more; pulses under two core clocks may be
// swallowed by the pin filters, the price of immunity to glitches.
//
// Functional notes
// RULE1: Address captured from shared lines at falling edge of latch strobe.
// RULE2: Same eight lines carry address first, then data.
// RULE3: Host has address stable before latch strobe ends.
// RULE4: Host keeps chip select low across read or write strobe.
// RULE5: Latch without chip select still captures address, moves no data.
// RULE6: Write strobe with select stores bus byte at latched address.
// RULE7: Host holds write data stable through end of write strobe.
// RULE8: Read strobe with select drives addressed byte onto the lines.
// RULE9: Lines released when read strobe rises; read strobe enables drivers.
// RULE10: Extended RAM uses same lines and strobes as clock registers.
// RULE11: Latched address holds until next latch strobe falling edge.
// RULE12: Without chip select, lines never driven and strobes ignored; the latch strobe still captures the address here.
`include "bus_port_params.svh"
module muxed_host_bus_port (
    // Clock and reset
    input wire logic core_clk_in,
    input wire logic nrst_in,
    // Host pins
    input wire logic ale_in,
    input wire logic sel_n_in,
    input wire logic rd_n_in,
    input wire logic wr_n_in,
    input wire bus_port_pkg::bus_byte_t shared_bus_lines_in,
    output bus_port_pkg::bus_byte_t shared_bus_lines_out,
    output logic shared_bus_lines_oe_out,
    // Storage side
    output bus_port_pkg::store_req_t store_req_out,
    output logic store_wr_out,
    input wire bus_port_pkg::bus_byte_t store_rdata_in
);
    import bus_port_pkg::*;

    // ****************************************
    // Pin synchronisation
    // ****************************************
    strobe_set_t strb;
    bus_byte_t bus_s;
    logic [3:0] strb_raw;
    pin_sync #(.W(4), .RST(`BP_SYNC_RST)) u_strb_sync (
        .core_clk_in(core_clk_in),
        .nrst_in(nrst_in),
        .pin_in({ale_in, sel_n_in, rd_n_in, wr_n_in}),
        .level_out(strb_raw)
    );
    assign strb = strobe_set_t'(strb_raw);
    // Data lines lag strobes equally, so samples line up
    pin_sync #(.W(`BP_BUS_W), .RST(`BP_DATA_RST)) u_bus_sync (
        .core_clk_in(core_clk_in),
        .nrst_in(nrst_in),
        .pin_in(shared_bus_lines_in),
        .level_out(bus_s)
    );

    // ****************************************
    // Strobe decode
    // ****************************************
    logic ale_d_r;
    logic ale_nxt;
    bus_byte_t bus_d_r;
    bus_byte_t bus_d_nxt;
    logic ale_fall;
    logic selected;
    logic rd_low;
    logic wr_low;
    logic rd_act;
    logic wr_act;
    assign ale_nxt = strb.ale;
    assign bus_d_nxt = bus_s; // RULE2
    // Compare with one cycle back so the address is the value before the edge
    assign ale_fall = ale_d_r & ~strb.ale; // RULE1
    assign selected = ~strb.sel_n; // RULE4 RULE5 RULE12
    assign rd_low = ~strb.rd_n;
    assign wr_low = ~strb.wr_n;
    // Both strobes low together is refused rather than guessed at
    assign rd_act = selected & rd_low & ~wr_low; // RULE8 RULE12
    assign wr_act = selected & wr_low & ~rd_low; // RULE6 RULE12

    always_ff @(posedge core_clk_in) begin
        if (!nrst_in) begin
            ale_d_r <= `BP_ALE_RST;
        end else begin
            ale_d_r <= ale_nxt;
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (!nrst_in) begin
            bus_d_r <= `BP_DATA_RST;
        end else begin
            bus_d_r <= bus_d_nxt;
        end
    end

    // ****************************************
    // Address latch
    // ****************************************
    bus_byte_t addr_r;
    bus_byte_t addr_nxt;
    // Taken whether or not the port is selected
    assign addr_nxt = ale_fall ? bus_d_r : addr_r; // RULE1 RULE3 RULE5 RULE11

    always_ff @(posedge core_clk_in) begin
        if (!nrst_in) begin
            addr_r <= `BP_ADDR_RST;
        end else begin
            addr_r <= addr_nxt;
        end
    end

    // ****************************************
    // Transfer state
    // ****************************************
    port_state_t state_r;
    port_state_t state_nxt;
    logic in_write;
    assign in_write = (state_r == ST_WRITE);

    // Any drop of strobe or select ends the transfer at once
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ST_IDLE: begin
                if (rd_act) begin
                    state_nxt = ST_READ;
                end else if (wr_act) begin
                    state_nxt = ST_WRITE;
                end
            end
            ST_READ: begin
                if (!rd_act) begin
                    state_nxt = ST_IDLE; // RULE9
                end
            end
            ST_WRITE: begin
                if (!wr_act) begin
                    state_nxt = ST_IDLE;
                end
            end
            default: state_nxt = ST_IDLE;
        endcase
    end

    always_ff @(posedge core_clk_in) begin
        if (!nrst_in) begin
            state_r <= ST_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // ****************************************
    // Write capture
    // ****************************************
    bus_byte_t wdata_r;
    bus_byte_t wdata_nxt;
    logic wr_commit;
    // Committed at the strobe's closing edge, once the byte has settled
    assign wr_commit = in_write & ~wr_act; // RULE6 RULE7
    // Last byte seen while the strobe was low wins
    assign wdata_nxt = wr_act ? bus_s : wdata_r; // RULE2 RULE7

    always_ff @(posedge core_clk_in) begin
        if (!nrst_in) begin
            wdata_r <= `BP_DATA_RST;
        end else begin
            wdata_r <= wdata_nxt;
        end
    end

    // ****************************************
    // Read drive
    // ****************************************
    bus_byte_t rd_byte;
    logic drive_nxt;
    assign drive_nxt = (state_nxt == ST_READ); // RULE8 RULE9 RULE12
    // Released lines idle at zero so no stale byte lingers
    assign rd_byte = drive_nxt ? store_rdata_in : `BP_DATA_RST; // RULE8 RULE10

    always_ff @(posedge core_clk_in) begin
        if (!nrst_in) begin
            shared_bus_lines_oe_out <= 1'b0;
        end else begin
            shared_bus_lines_oe_out <= drive_nxt; // RULE8 RULE9 RULE12
        end
    end

    // Data follows storage through a register while driving; a store mid-read shows one core clock later
    always_ff @(posedge core_clk_in) begin
        if (!nrst_in) begin
            shared_bus_lines_out <= `BP_DATA_RST;
        end else begin
            shared_bus_lines_out <= rd_byte;
        end
    end

    // ****************************************
    // Storage request
    // ****************************************
    store_req_t req_nxt;
    // One address space covers clock registers and extended RAM alike
    assign req_nxt = '{wr: wr_commit, addr: addr_nxt, data: wdata_r}; // RULE10

    always_ff @(posedge core_clk_in) begin
        if (!nrst_in) begin
            store_req_out <= '0;
        end else begin
            store_req_out <= req_nxt;
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (!nrst_in) begin
            store_wr_out <= 1'b0;
        end else begin
            store_wr_out <= wr_commit; // RULE6 RULE10
        end
    end
endmodule // muxed_host_bus_port

// ==== logic/bus_port_params.svh ====
// Constants for the multiplexed host bus port.
// Assumes inclusion by both design files; definitions only.
`ifndef BUS_PORT_PARAMS_SVH
`define BUS_PORT_PARAMS_SVH
`define BP_BUS_W 8
`define BP_ADDR_RST 8'h00
`define BP_DATA_RST 8'h00
// Strobe pins idle: latch low, select and strobes high
`define BP_SYNC_RST 4'h7
`define BP_ALE_RST 1'b0
`endif

// ==== logic/bus_port_pkg.sv ====
// Types shared by the host bus port design files.
// Assumes bus_port_params.svh is on the include path.
`include "bus_port_params.svh"
package bus_port_pkg;
    typedef logic [`BP_BUS_W-1:0] bus_byte_t;
    // Synchronised strobe levels: ale high-active, others low-active.
    typedef struct packed {
        logic ale;
        logic sel_n;
        logic rd_n;
        logic wr_n;
    } strobe_set_t;
    // Access toward the storage behind the port.
    typedef struct packed {
        logic wr;
        bus_byte_t addr;
        bus_byte_t data;
    } store_req_t;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_READ = 2'b01,
        ST_WRITE = 2'b10
    } port_state_t;
endpackage

// ==== logic/pin_sync.sv ====
// Three-stage pin synchroniser with agreement filter, one per bit.
// Assumes asynchronous pins and a single core clock.
module pin_sync #(
    parameter int W = 4,
    parameter logic [W-1:0] RST = '0
) (
    // Clock and reset
    input wire logic core_clk_in,
    input wire logic nrst_in,
    // Pins and filtered levels
    input wire logic [W-1:0] pin_in,
    output logic [W-1:0] level_out
);
    logic [W-1:0] s1_r;
    logic [W-1:0] s2_r;
    logic [W-1:0] s3_r;
    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_bit
            wire agree = (s2_r[i] == s3_r[i]);
            always_ff @(posedge core_clk_in) begin
                if (!nrst_in) begin
                    s1_r[i] <= RST[i];
                    s2_r[i] <= RST[i];
                    s3_r[i] <= RST[i];
                    level_out[i] <= RST[i];
                end else begin
                    s1_r[i] <= pin_in[i];
                    s2_r[i] <= s1_r[i];
                    s3_r[i] <= s2_r[i];
                    if (agree) begin
                        level_out[i] <= s3_r[i];
                    end
                end
            end
        end
    endgenerate
endmodule // pin_sync

// ==== tb/port_asserts.sv ====
// Concurrent checks on the multiplexed host bus port pins.
// Assumes binding onto muxed_host_bus_port; single core clock.
module port_asserts (
    // Clock and reset
    input wire logic core_clk_in,
    input wire logic nrst_in,
    // Host pins
    input wire logic ale_in,
    input wire logic sel_n_in,
    input wire logic rd_n_in,
    input wire logic wr_n_in,
    input wire bus_port_pkg::bus_byte_t shared_bus_lines_in,
    // Port drive
    input wire bus_port_pkg::bus_byte_t shared_bus_lines_out,
    input wire logic shared_bus_lines_oe_out,
    // Storage side
    input wire bus_port_pkg::store_req_t store_req_out,
    input wire logic store_wr_out,
    input wire bus_port_pkg::bus_byte_t store_rdata_in
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge core_clk_in); endclocking
    default disable iff (!nrst_in);
    // ****
    // Sequences and properties
    // ****
    sequence s_latch; $fell(ale_in); endsequence
    sequence s_rd_on; (!rd_n_in && !sel_n_in && wr_n_in)[*8]; endsequence
    property p_addr_cap;
        s_latch |-> ##8 store_req_out.addr == $past(shared_bus_lines_in, 8);
    endproperty
    property p_addr_hold; (!ale_in)[*8] ##1 (!ale_in)[*4] |-> $stable(store_req_out.addr);
    endproperty
    property p_desel; sel_n_in[*8] |-> !shared_bus_lines_oe_out && !store_wr_out; endproperty
    property p_rd_on; s_rd_on |-> shared_bus_lines_oe_out; endproperty
    property p_oe_cause; $rose(shared_bus_lines_oe_out) |-> !rd_n_in && !sel_n_in; endproperty
    property p_rd_off; rd_n_in[*8] |-> !shared_bus_lines_oe_out; endproperty
    property p_rd_data; shared_bus_lines_oe_out && $past(shared_bus_lines_oe_out)
        |-> shared_bus_lines_out == store_rdata_in; endproperty
    property p_wr; store_wr_out |-> !$past(wr_n_in, 8) && !sel_n_in && store_req_out.wr
        ##1 !store_wr_out; endproperty
    a_addr_cap: assert property (p_addr_cap) else $error("address not captured");
    a_addr_hold: assert property (p_addr_hold) else $error("address moved");
    a_desel: assert property (p_desel) else $error("active while deselected");
    a_rd_on: assert property (p_rd_on) else $error("read not driven");
    a_oe_cause: assert property (p_oe_cause) else $error("drive without read");
    a_rd_off: assert property (p_rd_off) else $error("bus not released");
    a_rd_data: assert property (p_rd_data) else $error("read byte wrong");
    a_wr: assert property (p_wr) else $error("bad write pulse");
endmodule // port_asserts

// ==== tb/host_model.sv ====
// Host on the far side: latches an address, then runs strobes.
// Assumes the bench calls cyc hierarchically; outputs move at rising edges.
module host_model
    import bus_port_pkg::*;
(
    // Clock and port drive
    input wire logic clk_in,
    input wire logic oe_in,
    input wire bus_byte_t dout_in,
    // Host pins
    output logic ale_out,
    output logic sel_n_out,
    output logic rd_n_out,
    output logic wr_n_out,
    output bus_byte_t bus_out
);
    timeunit 1ns;
    timeprecision 1ps;
    bus_byte_t hv = 8'h00;
    logic hen = 1'b0;
    initial {ale_out, sel_n_out, rd_n_out, wr_n_out} = 4'b0111;
    // Released lines show the inverse, never a stale copy
    assign bus_out = oe_in ? dout_in : (hen ? hv : ~hv);
    task automatic cyc(input bus_byte_t a, input bus_byte_t d, input logic wr,
                       input logic sv, input int n);
        @(posedge clk_in);
        hen <= 1'b1;
        hv <= a;
        ale_out <= 1'b1;
        repeat (10) @(posedge clk_in);
        ale_out <= 1'b0;
        for (int i = 0; i < n; i++) begin
            repeat (2) @(posedge clk_in);
            sel_n_out <= sv;
            hen <= wr;
            hv <= d;
            wr_n_out <= !wr;
            rd_n_out <= wr;
            repeat (18) @(posedge clk_in);
            {rd_n_out, wr_n_out} <= 2'b11;
            repeat (8) @(posedge clk_in);
            sel_n_out <= 1'b1;
            hen <= 1'b0;
        end
    endtask
endmodule // host_model

// ==== tb/testbench.sv ====
// Self-checking bench: random writes, read-back, deselected cycles.
// Assumes host_model and port_asserts compiled before.
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import bus_port_pkg::*;
    logic clk = 1'b0, nrst = 1'b0, ale, sel_n, rd_n, wr_n, oe, swr, poe = 1'b0;
    bus_byte_t bus, dout, rdata, pout, mem[256], em[256], rq[$], a, d;
    store_req_t req;
    logic [15:0] wq[$];
    int failures = 0, n_tests = 0, seed = 32'h7742;
    always #5 clk = ~clk;
    assign rdata = mem[req.addr];
    host_model i_host(.clk_in(clk), .oe_in(oe), .dout_in(dout), .ale_out(ale),
        .sel_n_out(sel_n), .rd_n_out(rd_n), .wr_n_out(wr_n), .bus_out(bus));
    muxed_host_bus_port i_dut(.core_clk_in(clk), .nrst_in(nrst), .ale_in(ale),
        .sel_n_in(sel_n), .rd_n_in(rd_n), .wr_n_in(wr_n), .shared_bus_lines_in(bus),
        .shared_bus_lines_out(dout), .shared_bus_lines_oe_out(oe), .store_req_out(req),
        .store_wr_out(swr), .store_rdata_in(rdata));
    task automatic chk_rd(input bus_byte_t got);
        n_tests++;
        if (rq.size() == 0 || rq[0] !== got) begin
            failures++;
            $display("ERROR %0t read byte mismatch", $time);
        end
        if (rq.size() != 0) rq.delete(0);
    endtask
    task automatic chk_wr(input logic [15:0] got);
        n_tests++;
        if (wq.size() == 0 || wq[0] !== got) begin
            failures++;
            $display("ERROR %0t store write mismatch", $time);
        end
        if (wq.size() != 0) wq.delete(0);
    endtask
    task automatic final_report();
        // Results still queued were never produced by the port
        if (rq.size() != 0 || wq.size() != 0) begin
            failures++;
            $display("ERROR %0t expected results never seen", $time);
        end
        $display("failures=%0d n_tests=%0d", failures, n_tests);
        if (failures == 0 && n_tests > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    always @(posedge clk) begin
        poe <= oe;
        pout <= dout;
        if (swr) mem[req.addr] <= req.data;
        if (poe && !oe) chk_rd(pout);
        if (swr) chk_wr({req.addr, req.data});
    end
    initial begin
        for (int i = 0; i < 256; i++) {mem[i], em[i]} = 16'h0000;
        repeat (12) @(posedge clk);
        nrst <= 1'b1;
        for (int i = 0; i < 16; i++) begin
            a = bus_byte_t'($random(seed));
            d = bus_byte_t'($random(seed));
            wq.push_back({a, d});
            em[a] = d;
            i_host.cyc(a, d, 1'b1, 1'b0, 1);
            rq.push_back(em[a]);
            rq.push_back(em[a]);
            i_host.cyc(a, 8'h00, 1'b0, 1'b0, 2);
        end
        // Deselected cycles latch a fresh address but must move no data
        a = ~a;
        i_host.cyc(a, ~d, 1'b1, 1'b1, 1);
        i_host.cyc(a, 8'h00, 1'b0, 1'b1, 1);
        rq.push_back(em[a]);
        i_host.cyc(a, 8'h00, 1'b0, 1'b0, 1);
        repeat (10) @(posedge clk);
        final_report();
    end
    initial begin
        repeat (60000) @(posedge clk);
        failures++;
        final_report();
    end
endmodule // testbench
bind muxed_host_bus_port port_asserts i_chk(.core_clk_in(core_clk_in), .nrst_in(nrst_in),
    .ale_in(ale_in), .sel_n_in(sel_n_in), .rd_n_in(rd_n_in), .wr_n_in(wr_n_in),
    .shared_bus_lines_in(shared_bus_lines_in), .shared_bus_lines_out(shared_bus_lines_out),
    .shared_bus_lines_oe_out(shared_bus_lines_oe_out), .store_req_out(store_req_out),
    .store_wr_out(store_wr_out), .store_rdata_in(store_rdata_in));
